// ===== hdl/idc_map.svh
// constants of the instruction decode and fault check block
`ifndef IDC_MAP_SVH
`define IDC_MAP_SVH

// register byte offsets
`define IDC_OFF_CTRL        8'h00
`define IDC_OFF_FLAGS       8'h04
`define IDC_OFF_STATUS      8'h08
`define IDC_OFF_COUNT       8'h0C

// control register fields
`define IDC_CTRL_PROT_BIT   0
`define IDC_CTRL_PRIV_LSB   1
`define IDC_CTRL_RST        32'h0000_0000

// flag word fields
`define IDC_FLG_ZERO_BIT    6
`define IDC_FLG_IF_BIT      9
`define IDC_FLG_IOPRIV_LSB  12
`define IDC_FLG_NEST_BIT    14
`define IDC_FLG_RST         16'h0002

// exception vectors
`define IDC_VEC_NONE        8'h00
`define IDC_VEC_UNDEF       8'h06
`define IDC_VEC_XSEG        8'h09
`define IDC_VEC_NP          8'h0B
`define IDC_VEC_STACK       8'h0C
`define IDC_VEC_GP          8'h0D

// move instruction clock counts
`define IDC_MOV_REG_CLK     6'd2
`define IDC_MOV_RM_MEM_CLK  6'd3
`define IDC_MOV_MR_MEM_CLK  6'd5
`define IDC_MOV_LDACC_CLK   6'd5
`define IDC_MOV_STACC_CLK   6'd3

// processor clock is the input clock divided by this
`define IDC_CLK_DIV         2
// highest word offset of a segment
`define IDC_SEG_TOP         16'hFFFF

`endif

// ===== hdl/idc_pkg.sv
// types of the instruction decode and fault check block
package idc_pkg;

   // instruction class supplied by the fetch path
   typedef enum logic [3:0] {
      IDC_K_PLAIN,
      IDC_K_PROT_ONLY,
      IDC_K_PRIV,
      IDC_K_IOSENS,
      IDC_K_FLAGLD,
      IDC_K_SELCHK,
      IDC_K_FARXFER,
      IDC_K_SEGLD,
      IDC_K_COPRO,
      IDC_K_XCHG,
      IDC_K_MULTI
   } idc_kind_t;

   typedef enum logic {
      IDC_IDLE,
      IDC_EXEC
   } idc_state_t;

endpackage

// ===== hdl/idc_phase.sv
// processor clock phase generator, one tick per two input clocks
`timescale 1ns/10ps
`include "idc_map.svh"
module idc_phase
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   logic [1:0] div_ff;
   logic [1:0] nxt_div;

   // count input clocks, tick on the last of each processor clock
   assign nxt_div = (div_ff == 2'(`IDC_CLK_DIV - 1)) ? 2'b00 : div_ff + 2'b01;
   assign tick_o  = (div_ff == 2'(`IDC_CLK_DIV - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         div_ff <= 2'b00;
      else
         div_ff <= nxt_div;
   end
endmodule

// ===== hdl/idc_decode.sv
// instruction decode and fault check with ahb-lite register port
//
// Summary of operation
// - direction bit one makes register the destination, memory for accumulator moves
// - width bit one means word, zero byte
// - sign bit set sign-extends one immediate byte
// - register operand smaller count, memory larger
// - three-part offset adds one clock
// - protected-only instruction in real mode: vector 6
// - real mode word at FFFF: vector 13
// - real mode flag load zeroes io privilege, nesting
// - real mode coprocessor overrun: vector 9
// - marked instructions lock bus regardless of prefix
// - multi-transfer lock may drop between transfers
// - protected memory fault 13, stack limit 12
// - segment load privilege check, not-present 11/12
// - descriptor table accesses assert bus lock
// - far transfer privilege violation: vector 13
// - far transfer beyond code limit: vector 13
// - privileged instruction with nonzero privilege: 13
// - i/o instruction above io privilege: 13
// - flag load guards interrupt enable, io privilege
// - selector violation: no result, zero flag cleared
// - escape: start 13/12, transfer fault 9
// - processor clock is half the input clock
`timescale 1ns/10ps
`include "idc_map.svh"
module idc_decode
   import idc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        ins_valid_i,
   output logic             ins_ready_o,
   input  wire idc_kind_t   ins_kind_i,
   input  wire logic [7:0]  ins_op_i,
   input  wire logic [7:0]  ins_modrm_i,
   input  wire logic [15:0] ins_imm_i,
   input  wire logic [15:0] ins_offs_i,
   input  wire logic        ins_ea3_i,
   input  wire logic        ins_lockpfx_i,
   input  wire logic [5:0]  ins_clk_reg_i,
   input  wire logic [5:0]  ins_clk_mem_i,
   input  wire logic        chk_lim_i,
   input  wire logic        chk_acc_i,
   input  wire logic        chk_stack_i,
   input  wire logic        chk_present_i,
   input  wire logic        chk_xfer_i,
   input  wire logic        chk_dest_ss_i,
   input  wire logic [1:0]  chk_req_priv_i,
   input  wire logic [1:0]  chk_desc_priv_i,
   output logic             dec_valid_o,
   output logic             dec_reg_dest_o,
   output logic             dec_word_o,
   output logic      [15:0] dec_imm_o,
   output logic      [5:0]  dec_clocks_o,
   output logic             dec_no_result_o,
   output logic             exc_o,
   output logic      [7:0]  exc_vec_o,
   output logic             lock_o,
   output logic             proc_tick_o
);
   idc_state_t  state_ff, nxt_state;
   logic [31:0] ctrl_ff, hrdata_ff;
   logic [15:0] flags_ff, nxt_flags, exc_cnt_ff, ins_cnt_ff;
   logic [5:0]  cnt_ff, nxt_cnt;
   logic [7:0]  wr_addr_ff, last_vec_ff;
   logic        wr_pend_ff;
   logic [1:0]  lock_sel_ff, nxt_lock_sel;
   logic        lock_ff;
   logic        dec_valid_ff, reg_dest_ff, word_ff, no_res_ff, exc_ff;
   logic [15:0] imm_ff;
   logic [5:0]  clocks_ff;
   logic [7:0]  vec_ff;

   // processor clock phase
   idc_phase u_phase
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (proc_tick_o)
   );

   // mode and privilege context
   wire       prot   = ctrl_ff[`IDC_CTRL_PROT_BIT];
   wire       real_m = ~prot;
   wire [1:0] cur_priv = ctrl_ff[`IDC_CTRL_PRIV_LSB +: 2];
   wire [1:0] io_priv  = flags_ff[`IDC_FLG_IOPRIV_LSB +: 2];
   wire       accept = ins_valid_i & ins_ready_o;

   // opcode field decode, move forms first
   wire [7:0] op         = ins_op_i;
   wire       mod_mem    = (ins_modrm_i[7:6] != 2'b11);
   wire       mov_rm     = (op[7:2] == 6'b100010);
   wire       mov_imm_rm = (op[7:1] == 7'b1100011);
   wire       mov_imm_rg = (op[7:4] == 4'b1011);
   wire       mov_acc    = (op[7:2] == 6'b101000);
   wire       sx_form    = (op[7:2] == 6'b100000);
   wire       is_mov     = mov_rm | mov_imm_rm | mov_imm_rg | mov_acc;
   wire       d_bit      = op[1];
   wire       s_bit      = op[1];

   // width bit sits at bit 3 for the short immediate move
   wire word_op = mov_imm_rg ? op[3] : op[0];

   // register field as destination or source
   wire reg_dest = mov_imm_rg ? 1'b1 :
                   mov_imm_rm ? 1'b0 :
                   mov_acc    ? ~d_bit : d_bit;

   // memory operand present
   wire mem_opnd = mov_imm_rg ? 1'b0 : mov_acc ? 1'b1 : mod_mem;

   // immediate operand forming
   wire [15:0] imm_sx  = {{8{ins_imm_i[7]}}, ins_imm_i[7:0]};
   wire [15:0] imm_val = (sx_form & s_bit) ? imm_sx :
                         word_op ? ins_imm_i : {8'h00, ins_imm_i[7:0]};

   // clock counts of the move forms
   wire [5:0] mov_mem_clk = mov_acc ? (d_bit ? `IDC_MOV_STACC_CLK : `IDC_MOV_LDACC_CLK) :
                            (mov_rm & d_bit) ? `IDC_MOV_MR_MEM_CLK : `IDC_MOV_RM_MEM_CLK;
   wire [5:0] reg_clk     = is_mov ? `IDC_MOV_REG_CLK : ins_clk_reg_i;
   wire [5:0] mem_clk     = is_mov ? mov_mem_clk : ins_clk_mem_i;
   wire [5:0] base_clk    = mem_opnd ? mem_clk : reg_clk;
   wire       ea3_extra   = mem_opnd & ~mov_acc & ins_ea3_i;
   wire [5:0] tot_clk     = base_clk + {5'd0, ea3_extra};

   // privilege compares
   wire [1:0] eff_pl   = (cur_priv > chk_req_priv_i) ? cur_priv : chk_req_priv_i;
   wire       sel_viol = (eff_pl > chk_desc_priv_i);
   wire       far_viol = (chk_desc_priv_i > cur_priv) | sel_viol;
   wire       k_prot   = (ins_kind_i == IDC_K_PROT_ONLY);
   wire       k_copro  = (ins_kind_i == IDC_K_COPRO);
   wire       k_seg    = (ins_kind_i == IDC_K_SEGLD);
   wire       k_far    = (ins_kind_i == IDC_K_FARXFER);
   wire       k_sel    = (ins_kind_i == IDC_K_SELCHK);

   // individual fault conditions
   wire f_undef   = real_m & k_prot;
   wire f_priv    = prot & (ins_kind_i == IDC_K_PRIV) & (cur_priv != 2'b00);
   wire f_io      = prot & (ins_kind_i == IDC_K_IOSENS) & (cur_priv > io_priv);
   wire f_wrap    = real_m & word_op & mem_opnd & (ins_offs_i == `IDC_SEG_TOP);
   wire f_resc    = real_m & k_copro & (chk_lim_i | chk_xfer_i);
   wire f_farpl   = prot & k_far & far_viol;
   wire f_farlim  = prot & k_far & chk_lim_i;
   wire f_segpl   = prot & k_seg & sel_viol;
   wire f_segnp   = prot & k_seg & ~chk_present_i;
   wire f_mem     = prot & (mem_opnd | k_copro) & ~k_far & (chk_lim_i | chk_acc_i);
   wire f_pesc    = prot & k_copro & chk_xfer_i;
   wire sel_quiet = prot & k_sel & sel_viol;

   // vector selection in priority order
   wire [7:0] vec =
      f_undef              ? `IDC_VEC_UNDEF :
      (f_priv | f_io)      ? `IDC_VEC_GP    :
      (f_farpl | f_farlim) ? `IDC_VEC_GP    :
      f_segpl              ? `IDC_VEC_GP    :
      f_segnp              ? (chk_dest_ss_i ? `IDC_VEC_STACK : `IDC_VEC_NP) :
      f_mem                ? (chk_stack_i ? `IDC_VEC_STACK : `IDC_VEC_GP) :
      f_wrap               ? `IDC_VEC_GP    :
      (f_resc | f_pesc)    ? `IDC_VEC_XSEG  : `IDC_VEC_NONE;
   wire fault = (vec != `IDC_VEC_NONE);

   // flag word load with mode guards
   wire        do_flagld = accept & ~fault & (ins_kind_i == IDC_K_FLAGLD);
   wire [15:0] fl_src    = ins_imm_i;
   wire        fl_if_keep = prot & (cur_priv > io_priv);
   wire        fl_if     = fl_if_keep ? flags_ff[`IDC_FLG_IF_BIT] : fl_src[`IDC_FLG_IF_BIT];
   wire [1:0]  fl_iopriv = real_m ? 2'b00 :
                           (cur_priv == 2'b00) ? fl_src[`IDC_FLG_IOPRIV_LSB +: 2] : io_priv;
   wire        fl_nest   = real_m ? 1'b0 : fl_src[`IDC_FLG_NEST_BIT];
   wire [15:0] fl_loaded = {fl_src[15], fl_nest, fl_iopriv, fl_src[11:10], fl_if, fl_src[8:0]};

   // ahb-lite address phase and register decode
   wire       ahb_go   = hsel_i & hready_i & htrans_i[1];
   wire [7:0] a_off    = haddr_i[7:0];
   wire       hit_ctrl = (wr_addr_ff == `IDC_OFF_CTRL);
   wire       hit_flg  = (wr_addr_ff == `IDC_OFF_FLAGS);
   wire [31:0] status_w = {22'd0, lock_ff, (state_ff == IDC_EXEC), last_vec_ff};
   wire [31:0] rd_mux  =
      (a_off == `IDC_OFF_CTRL)   ? ctrl_ff :
      (a_off == `IDC_OFF_FLAGS)  ? {16'h0000, flags_ff} :
      (a_off == `IDC_OFF_STATUS) ? status_w :
      (a_off == `IDC_OFF_COUNT)  ? {exc_cnt_ff, ins_cnt_ff} : 32'h0000_0000;

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_ff;

   // flag word next value, instruction load wins over software
   always_comb
   begin
      nxt_flags = flags_ff;
      if (wr_pend_ff & hit_flg)
         nxt_flags = hwdata_i[15:0];
      if (sel_quiet & accept)
         nxt_flags[`IDC_FLG_ZERO_BIT] = 1'b0;
      if (do_flagld)
         nxt_flags = fl_loaded;
   end

   // execution sequencer counting processor clocks
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         IDC_IDLE:
         begin
            if (accept & ~fault)
            begin
               nxt_state = IDC_EXEC;
               nxt_cnt   = tot_clk;
            end
         end
         IDC_EXEC:
         begin
            if (proc_tick_o)
            begin
               nxt_cnt = cnt_ff - 6'd1;
               if (cnt_ff <= 6'd1)
                  nxt_state = IDC_IDLE;
            end
         end
      endcase
   end
   assign ins_ready_o = (state_ff == IDC_IDLE);

   // lock mode: 0 none, 1 whole instruction, 2 alternate clocks
   assign nxt_lock_sel =
      (ins_kind_i == IDC_K_MULTI) ? 2'd2 :
      ((ins_kind_i == IDC_K_XCHG) & mem_opnd) | ins_lockpfx_i ? 2'd1 :
      (prot & (k_seg | k_far)) ? 2'd1 : 2'd0;

   // bus lock driven from a flip-flop, mode of the new instruction from its accept
   wire [1:0] lock_mode = accept ? nxt_lock_sel : lock_sel_ff;
   wire lock_next = (nxt_state == IDC_EXEC) &
                    ((lock_mode == 2'd1) | ((lock_mode == 2'd2) & nxt_cnt[0]));

   // bus write data phase and read capture
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= ahb_go & hwrite_i;
         wr_addr_ff <= a_off;
         hrdata_ff  <= (ahb_go & ~hwrite_i) ? rd_mux : hrdata_ff;
      end
   end

   // control register and flag word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff  <= `IDC_CTRL_RST;
         flags_ff <= `IDC_FLG_RST;
      end
      else
      begin
         ctrl_ff  <= (wr_pend_ff & hit_ctrl) ? {29'd0, hwdata_i[2:0]} : ctrl_ff;
         flags_ff <= nxt_flags;
      end
   end

   // sequencer, lock and counters
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff    <= IDC_IDLE;
         cnt_ff      <= 6'd0;
         lock_sel_ff <= 2'd0;
         lock_ff     <= 1'b0;
         last_vec_ff <= `IDC_VEC_NONE;
         exc_cnt_ff  <= 16'h0000;
         ins_cnt_ff  <= 16'h0000;
      end
      else
      begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         lock_sel_ff <= lock_mode;
         lock_ff     <= lock_next;
         last_vec_ff <= (accept & fault) ? vec : last_vec_ff;
         exc_cnt_ff  <= exc_cnt_ff + {15'd0, accept & fault};
         ins_cnt_ff  <= ins_cnt_ff + {15'd0, accept & ~fault};
      end
   end
   assign lock_o = lock_ff;

   // decode fields held until the next accepted instruction, valid and fault flags for one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dec_valid_ff <= 1'b0;
         exc_ff       <= 1'b0;
         vec_ff       <= `IDC_VEC_NONE;
         reg_dest_ff  <= 1'b0;
         word_ff      <= 1'b0;
         imm_ff       <= 16'h0000;
         clocks_ff    <= 6'd0;
         no_res_ff    <= 1'b0;
      end
      else
      begin
         dec_valid_ff <= accept & ~fault;
         exc_ff       <= accept & fault;
         vec_ff       <= accept ? vec : vec_ff;
         reg_dest_ff  <= accept ? reg_dest : reg_dest_ff;
         word_ff      <= accept ? word_op : word_ff;
         imm_ff       <= accept ? imm_val : imm_ff;
         clocks_ff    <= accept ? tot_clk : clocks_ff;
         no_res_ff    <= accept ? sel_quiet : no_res_ff;
      end
   end
   assign dec_valid_o     = dec_valid_ff;
   assign exc_o           = exc_ff;
   assign exc_vec_o       = vec_ff;
   assign dec_reg_dest_o  = reg_dest_ff;
   assign dec_word_o      = word_ff;
   assign dec_imm_o       = imm_ff;
   assign dec_clocks_o    = clocks_ff;
   assign dec_no_result_o = no_res_ff;

   // helper: input clocks spent executing
   logic [7:0] run_ff;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         run_ff <= 8'd0;
      else
         run_ff <= (state_ff == IDC_EXEC) ? run_ff + 8'd1 : 8'd0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   exec_length_a: assert property (($fell(state_ff == IDC_EXEC)) |->
      ($past(run_ff) >= 8'(2 * dec_clocks_o - 2)) && ($past(run_ff) <= 8'(2 * dec_clocks_o - 1)))
      else $error("execution length not two input clocks per count");
   move_count_a: assert property ((accept & ~fault & mov_rm & ~d_bit & ~mod_mem) |=>
      dec_clocks_o == 6'd2)
      else $error("register move count wrong");
   ea3_count_a: assert property ((accept & ~fault & mov_rm & d_bit & mod_mem & ins_ea3_i) |=>
      dec_clocks_o == 6'd6)
      else $error("three part offset clock missing");
   dir_width_a: assert property ((accept & mov_rm) |=>
      dec_reg_dest_o == $past(op[1]) && dec_word_o == $past(op[0]))
      else $error("direction or width decode wrong");
   sign_ext_a: assert property ((accept & sx_form & op[1]) |=>
      dec_imm_o[15:8] == {8{dec_imm_o[7]}})
      else $error("immediate byte not sign extended");
   undef_vec_a: assert property ((accept & real_m & k_prot) |=>
      exc_o && exc_vec_o == 8'h06 && !dec_valid_o)
      else $error("undefined opcode vector missing");
   wrap_vec_a: assert property ((accept & real_m & ~k_prot & ~k_copro & word_op & mem_opnd
      & ins_offs_i == 16'hFFFF) |=> exc_o && exc_vec_o == 8'h0D)
      else $error("segment overrun at top offset missing");
   priv_gp_a: assert property ((accept & prot & ins_kind_i == IDC_K_PRIV & cur_priv != 2'b00) |=>
      exc_o && exc_vec_o == 8'h0D)
      else $error("privileged instruction not trapped");
   real_flags_a: assert property (do_flagld & real_m |=>
      flags_ff[14:12] == 3'b000)
      else $error("real mode flag load left io privilege or nesting set");
   sel_quiet_a: assert property ((accept & sel_quiet) |=>
      !exc_o && dec_no_result_o && !flags_ff[6])
      else $error("selector violation not silent");
   xchg_lock_a: assert property ((accept & ~fault & ins_kind_i == IDC_K_XCHG & mem_opnd) |=>
      lock_o [*2])
      else $error("exchange did not lock the bus");

   fault_seen_c: cover property (accept & fault ##1 exc_o);
   move_run_c:   cover property (accept & is_mov & ~fault ##[2:40] ins_ready_o);
   multi_lock_c: cover property (lock_sel_ff == 2'd2 && lock_o ##1 !lock_o [*2] ##1 lock_o);
endmodule

// ===== dv/idc_fetch_model.sv
// fetch path model that offers one instruction word at a time
`timescale 1ns/10ps
module idc_fetch_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        req_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic [65:0] word_i,
   input  wire logic        ready_i,
   output logic             valid_o,
   output logic      [65:0] word_o
);
   logic [3:0] wait_ff;

   // offer after gap_i idle cycles, hold until taken, then scramble lines
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         valid_o <= 1'h0;
         word_o  <= '0;
         wait_ff <= 4'h0;
      end
      else if (valid_o && ready_i)
      begin
         valid_o <= 1'h0;
         word_o  <= ~word_o; // released lines never keep the last value
      end
      else if (req_i && !valid_o)
      begin
         if (wait_ff == gap_i)
         begin
            valid_o <= 1'h1;
            word_o  <= word_i;
            wait_ff <= 4'h0;
         end
         else
            wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule

// ===== dv/instruction_decode_and_fault_check_tb_top.sv
// self-checking testbench of the instruction decode and fault check block
`timescale 1ns/10ps
`include "idc_map.svh"
module instruction_decode_and_fault_check_tb_top
   import idc_pkg::*;
;
   logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i, ins_valid_i, req, lp, e3;
   logic [31:0] haddr_i, hwdata_i, hrdata_o;
   logic [1:0]  htrans_i, chk_req_priv_i, chk_desc_priv_i;
   logic [2:0]  hsize_i;
   idc_kind_t   ins_kind_i;
   logic [7:0]  ins_op_i, ins_modrm_i, exc_vec_o, op, md;
   logic [15:0] ins_imm_i, ins_offs_i, dec_imm_o;
   logic [5:0]  ins_clk_reg_i, ins_clk_mem_i, dec_clocks_o;
   logic        ins_ea3_i, ins_lockpfx_i, hreadyout_o, hresp_o, ins_ready_o;
   logic        chk_lim_i, chk_acc_i, chk_stack_i, chk_present_i, chk_xfer_i;
   logic        chk_dest_ss_i, dec_valid_o, dec_reg_dest_o, dec_word_o;
   logic        dec_no_result_o, exc_o, lock_o, proc_tick_o;
   logic [65:0] wd, fw;
   logic [3:0]  gap;
   logic [9:0]  ck;
   int          n_fail, total_checks, n_ok, n_bad, i;
   localparam logic [9:0] P = 10'h040; // descriptor present, no violation
   localparam logic       X = 1'hx;    // lock not compared

   // check lines, one bus
   assign hready_i = hreadyout_o;
   assign {chk_lim_i, chk_acc_i, chk_stack_i, chk_present_i, chk_xfer_i,
           chk_dest_ss_i, chk_req_priv_i, chk_desc_priv_i} = ck;
   assign ins_kind_i = idc_kind_t'(fw[65:62]);
   assign {ins_op_i, ins_modrm_i, ins_imm_i, ins_offs_i, ins_ea3_i,
           ins_lockpfx_i, ins_clk_reg_i, ins_clk_mem_i} = fw[61:0];

   idc_decode dut (.*);
   idc_fetch_model fetch (.clk_i, .rst_i, .req_i(req), .gap_i(gap), .word_i(wd),
                          .ready_i(ins_ready_o), .valid_o(ins_valid_i), .word_o(fw));

   // 200 MHz clock
   initial
   begin
      clk_i = 1'h0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic final_report();
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, s);
      total_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask

   // wait for hready high at a rising edge
   task automatic hwait();
      for (int k = 0; k <= 50; k++)
      begin
         @(posedge clk_i);
         if (hreadyout_o === 1'h1)
            return;
      end
      n_fail++;
      final_report();
   endtask

   // one single word transfer
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk_i);
      hsel_i   <= 1'h1;
      htrans_i <= 2'h2;
      haddr_i  <= a;
      hwrite_i <= w;
      hwait();
      hsel_i   <= 1'h0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      hwait();
      r = hrdata_o;
   endtask

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'h1, a, d, r);
   endtask

   task automatic rchk(input logic [31:0] a, e);
      logic [31:0] r;
      bus(1'h0, a, 32'h0, r);
      cmp("register", e, r);
      cmp("hresp", 32'h0, hresp_o);
   endtask

   // expected move clock count
   function automatic logic [5:0] mclk(input logic [7:0] o, m, input logic e);
      if (o[7:4] == 4'hB || (o[7:4] != 4'hA && m[7:6] == 2'h3))
         return 6'h2;
      if (o[7:4] == 4'hA)
         return o[1] ? 6'h3 : 6'h5;
      return (o[7:1] == 7'h45 ? 6'h5 : 6'h3) + {5'h0, e};
   endfunction

   // offer one instruction and check fault, count, lock and busy span
   task automatic run(input idc_kind_t k, input logic [7:0] o, m, input logic [15:0] im, of,
                      input logic [9:0] c, input logic [7:0] xv, input logic [5:0] xc,
                      input logic xl, input logic e = 1'h0);
      int n;
      @(posedge clk_i);
      ck  <= c;
      wd  <= {k, o, m, im, of, e, lp, 6'h4, 6'h9};
      gap <= 4'($urandom % 3);
      req <= 1'h1;
      for (n = 0; n <= 60; n++)
      begin
         @(negedge clk_i);
         if (ins_valid_i && ins_ready_o)
            break;
      end
      if (n > 60)
      begin
         n_fail++;
         final_report();
      end
      @(posedge clk_i);
      req <= 1'h0;
      @(negedge clk_i);
      cmp("fault", xv != 8'h0, exc_o);
      cmp("done", xv == 8'h0, dec_valid_o);
      if (xv != 8'h0)
         cmp("vector", xv, exc_vec_o);
      else if (xc != 6'h0)
         cmp("clocks", xc, dec_clocks_o);
      if (xv != 8'h0)
         n_bad++;
      else
         n_ok++;
      if (xl !== 1'hx)
         cmp("lock", xl, lock_o);
      for (n = 0; n <= 200 && ins_ready_o !== 1'h1; n++)
         @(negedge clk_i);
      if (xv == 8'h0 && xc != 6'h0)
         cmp("busy", 1, n >= 2 * xc - 1 && n <= 2 * xc);
      if (n > 200)
      begin
         n_fail++;
         final_report();
      end
   endtask

   initial
   begin
      {hsel_i, hwrite_i, req, lp, e3} = '0;
      rst_i = 1'h1;
      {haddr_i, hwdata_i, wd} = '0;
      {htrans_i, gap} = '0;
      hsize_i = 3'h2;
      ck = P;
      {n_fail, total_checks, n_ok, n_bad} = '0;
      void'($urandom(32'hd57a));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      for (i = 0; i < 4; i++)
      begin
         @(negedge clk_i);
         cmp("tick", i % 2, proc_tick_o);
      end
      rchk(`IDC_OFF_CTRL, 32'h0);
      rchk(`IDC_OFF_FLAGS, 32'h0002);
      rchk(32'h0010, 32'h0);
      // real address mode
      run(IDC_K_PROT_ONLY, 8'h0F, 8'hC0, 16'h0, 16'h0, P, 8'h06, 6'h0, X);
      run(IDC_K_PLAIN, 8'h8B, 8'h06, 16'h0, 16'hFFFF, P, 8'h0D, 6'h0, X);
      run(IDC_K_PLAIN, 8'h8A, 8'h06, 16'h0, 16'hFFFF, P, 8'h00, 6'h5, X);
      run(IDC_K_COPRO, 8'hD8, 8'h06, 16'h0, 16'h10, 10'h060, 8'h09, 6'h0, X);
      run(IDC_K_FLAGLD, 8'h9D, 8'hC0, 16'h7202, 16'h0, P, 8'h00, 6'h0, X);
      rchk(`IDC_OFF_FLAGS, 32'h0202);
      run(IDC_K_PLAIN, 8'h81, 8'hC0, 16'h1234, 16'h0, P, 8'h00, 6'h4, 1'h0);
      cmp("imm", 16'h1234, dec_imm_o);
      cmp("no_result", 1'h0, dec_no_result_o);
      run(IDC_K_PLAIN, 8'h83, 8'h06, 16'h1280, 16'h0, P, 8'h00, 6'h9, X);
      cmp("imm", 16'hFF80, dec_imm_o);
      run(IDC_K_PLAIN, 8'h83, 8'h00, 16'h0005, 16'h0, P, 8'h00, 6'hA, X, 1'h1);
      cmp("imm", 16'h0005, dec_imm_o);
      lp = 1'h1;
      run(IDC_K_PLAIN, 8'h81, 8'hC0, 16'h0, 16'h0, P, 8'h00, 6'h4, 1'h1);
      lp = 1'h0;
      run(IDC_K_XCHG, 8'h87, 8'h06, 16'h0, 16'h0, P, 8'h00, 6'h9, 1'h1);
      run(IDC_K_MULTI, 8'hA5, 8'hC0, 16'h0, 16'h0, P, 8'h00, 6'h0, X);
      // random move forms
      for (i = 0; i < 40; i++)
      begin
         case (2'($urandom))
            2'h0: op = 8'h88 | 8'($urandom % 4);
            2'h1: op = 8'hC6 | 8'($urandom % 2);
            2'h2: op = 8'hA0 | 8'($urandom % 4);
            default: op = 8'hB0 | 8'($urandom % 16);
         endcase
         md = 8'($urandom);
         e3 = (op[7:4] == 4'h8 || op[7:4] == 4'hC) ? 1'($urandom) : 1'h0;
         run(IDC_K_PLAIN, op, md, 16'($urandom), 16'($urandom % 32'hFFFF), P, 8'h00,
             mclk(op, md, e3), X, e3);
         cmp("word", op[7:4] == 4'hB ? op[3] : op[0], dec_word_o);
         if (op[7:2] == 6'h22)
            cmp("dest", op[1], dec_reg_dest_o);
      end
      // protected mode, privilege 0
      wr(`IDC_OFF_CTRL, 32'h1);
      run(IDC_K_FLAGLD, 8'h9D, 8'hC0, 16'h3202, 16'h0, P, 8'h00, 6'h0, X);
      rchk(`IDC_OFF_FLAGS, 32'h3202);
      run(IDC_K_PRIV, 8'h01, 8'hC0, 16'h0, 16'h0, P, 8'h00, 6'h0, X);
      run(IDC_K_SEGLD, 8'h8E, 8'h06, 16'h0, 16'h0, P, 8'h00, 6'h0, 1'h1);
      run(IDC_K_SEGLD, 8'h8E, 8'h06, 16'h0, 16'h0, 10'h000, 8'h0B, 6'h0, X);
      run(IDC_K_SEGLD, 8'h8E, 8'h06, 16'h0, 16'h0, 10'h010, 8'h0C, 6'h0, X);
      run(IDC_K_FARXFER, 8'hEA, 8'hC0, 16'h0, 16'h0, 10'h240, 8'h0D, 6'h0, X);
      run(IDC_K_FARXFER, 8'hEA, 8'hC0, 16'h0, 16'h0, 10'h04C, 8'h0D, 6'h0, X);
      run(IDC_K_PLAIN, 8'h8B, 8'h06, 16'h0, 16'h0, 10'h240, 8'h0D, 6'h0, X);
      run(IDC_K_PLAIN, 8'h8B, 8'h06, 16'h0, 16'h0, 10'h140, 8'h0D, 6'h0, X);
      run(IDC_K_PLAIN, 8'h8B, 8'h06, 16'h0, 16'h0, 10'h2C0, 8'h0C, 6'h0, X);
      run(IDC_K_COPRO, 8'hD8, 8'h06, 16'h0, 16'h0, 10'h240, 8'h0D, 6'h0, X);
      run(IDC_K_COPRO, 8'hD8, 8'h06, 16'h0, 16'h0, 10'h2C0, 8'h0C, 6'h0, X);
      run(IDC_K_COPRO, 8'hD8, 8'h06, 16'h0, 16'h0, 10'h060, 8'h09, 6'h0, X);
      // protected mode, privilege 3
      wr(`IDC_OFF_CTRL, 32'h7);
      run(IDC_K_PRIV, 8'h01, 8'hC0, 16'h0, 16'h0, P, 8'h0D, 6'h0, X);
      run(IDC_K_SEGLD, 8'h8E, 8'h06, 16'h0, 16'h0, P, 8'h0D, 6'h0, X);
      run(IDC_K_IOSENS, 8'hE4, 8'hC0, 16'h0, 16'h0, P, 8'h00, 6'h0, X);
      run(IDC_K_FLAGLD, 8'h9D, 8'hC0, 16'h0002, 16'h0, P, 8'h00, 6'h0, X);
      rchk(`IDC_OFF_FLAGS, 32'h3002);
      wr(`IDC_OFF_FLAGS, 32'h0002);
      run(IDC_K_IOSENS, 8'hE4, 8'hC0, 16'h0, 16'h0, P, 8'h0D, 6'h0, X);
      run(IDC_K_FLAGLD, 8'h9D, 8'hC0, 16'h3242, 16'h0, P, 8'h00, 6'h0, X);
      rchk(`IDC_OFF_FLAGS, 32'h0042);
      run(IDC_K_SELCHK, 8'h02, 8'hC0, 16'h0, 16'h0, 10'h04C, 8'h00, 6'h0, X);
      cmp("no_result", 1'h1, dec_no_result_o);
      rchk(`IDC_OFF_FLAGS, 32'h0002);
      rchk(`IDC_OFF_STATUS, 32'h0000_000D);
      rchk(`IDC_OFF_COUNT, {16'(n_bad), 16'(n_ok)});
      final_report();
   end
endmodule
